//--- hdl/flash_id_host.sv
module flash_id_host #(
    parameter int HALF_DIV = 4 // System clocks per serial clock half
) (
    spi_link_if.host                 link,
    input  wire logic                clk_sys,
    input  wire logic                reset_n,
    input  wire logic                start,
    input  wire flash_id_pkg::host_cmd_t cmd,
    input  wire logic [31:0]         address,
    input  wire logic [7:0]          byte_count,
    input  wire logic                four_bit_command_mode,
    input  wire logic                addr_len_four,
    input  wire logic [3:0]          read_latency,
    output logic [7:0]               rx_data,
    output logic                     rx_valid,
    output logic                     busy,
    output logic                     done
);
    import flash_id_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    // Three system clocks per half let the two-flop input path settle
    if (HALF_DIV < 3 || HALF_DIV > 255) begin
        $error("HALF_DIV out of range");
    end
    if (SYS_CLK_HZ / (2 * HALF_DIV) > ID_MAX_SCLK_HZ) begin
        $error("Serial clock too fast for identity read");
    end
    if (SYS_CLK_HZ / (2 * HALF_DIV) > TABLE_MAX_SCLK_HZ) begin
        $error("Serial clock too fast for table read");
    end

    localparam logic [7:0] HALF_LAST = 8'(HALF_DIV - 1);

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef enum logic [1:0] {H_IDLE, H_RUN, H_END} hphase_t;

    typedef struct packed {
        hphase_t     ph;
        logic [7:0]  div;
        logic        sclk;
        logic        cs_n;
        logic [3:0]  io_out;
        logic [3:0]  io_oe;
        logic [39:0] tx;       // Opcode then address, MSB first
        logic        wide_tx;  // Opcode and address on four lines
        logic        wide_rx;  // Data on four lines
        logic [15:0] edges;    // Rising edges done
        logic [15:0] tx_end;   // End of drive phase
        logic [15:0] rx_start; // End of dummy phase
        logic [15:0] total;    // Whole frame length
        logic [7:0]  rx;
        logic [2:0]  rpos;
        logic [7:0]  rx_data;
        logic        rx_valid;
        logic        done;
        logic [3:0]  meta;     // First input stage
        logic [3:0]  sync;     // Second input stage
    } host_state_t;

    host_state_t st;
    host_state_t next_st;
    logic [15:0] aedges;    // Address clocks for this start
    logic [15:0] dummies;   // Dummy clocks for this start
    logic        wtx;
    logic        wrx;

    // Frame shape from command and device config
    always_comb begin
        wtx     = four_bit_command_mode;
        wrx     = four_bit_command_mode || (cmd == CMD_QUAD_ID);
        aedges  = '0;
        dummies = '0;
        if (cmd == CMD_TABLE) begin
            aedges  = 16'(addr_len_four ? (wtx ? ADDR4_EDGES_QUAD : ADDR4_EDGES_SINGLE)
                                        : (wtx ? ADDR3_EDGES_QUAD : ADDR3_EDGES_SINGLE));
            dummies = {12'h000, read_latency};
        end else if (cmd == CMD_UNIQUE) begin
            dummies = 16'(UID_LATENCY);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame sequencer
    always_comb begin
        logic [7:0] opc;
        logic [7:0] rnext;
        opc              = OP_IDENTITY_READ;
        rnext            = '0;
        next_st          = st;
        next_st.rx_valid = 1'b0;
        next_st.done     = 1'b0;
        next_st.meta     = link.io;
        next_st.sync     = st.meta;
        unique case (st.ph)
            H_IDLE: begin
                if (start) begin
                    unique case (cmd)
                        CMD_ID:      opc = OP_IDENTITY_READ;
                        CMD_QUAD_ID: opc = OP_QUAD_IDENTITY;
                        CMD_TABLE:   opc = OP_PARAM_TABLE;
                        CMD_UNIQUE:  opc = OP_UNIQUE_SERIAL;
                    endcase
                    next_st.tx       = addr_len_four ? {opc, address} : {opc, address[23:0], 8'h00};
                    next_st.wide_tx  = wtx;
                    next_st.wide_rx  = wrx;
                    next_st.tx_end   = 16'(wtx ? OPC_EDGES_QUAD : OPC_EDGES_SINGLE) + aedges;
                    next_st.rx_start = next_st.tx_end + dummies;
                    next_st.total    = next_st.rx_start + (wrx ? {7'h00, byte_count, 1'b0}
                                                               : {5'h00, byte_count, 3'h0});
                    next_st.edges    = '0;
                    next_st.rpos     = '0;
                    next_st.div      = '0;
                    next_st.sclk     = 1'b0;
                    next_st.cs_n     = 1'b0;
                    next_st.io_out   = wtx ? next_st.tx[39:36] : {3'h0, next_st.tx[39]};
                    next_st.io_oe    = wtx ? 4'hf : 4'h1;
                    next_st.ph       = H_RUN;
                end
            end
            H_RUN: begin
                next_st.div = st.div + 8'h01;
                if (st.div == HALF_LAST) begin
                    next_st.div  = '0;
                    next_st.sclk = ~st.sclk;
                    if (!st.sclk) begin
                        // Rising edge: take a data bit or nibble
                        next_st.edges = st.edges + 16'h0001;
                        if (st.edges >= st.rx_start) begin
                            rnext        = st.wide_rx ? {st.rx[3:0], st.sync} : {st.rx[6:0], st.sync[1]};
                            next_st.rx   = rnext;
                            next_st.rpos = st.rpos + (st.wide_rx ? 3'h4 : 3'h1);
                            if (next_st.rpos == 3'h0) begin
                                next_st.rx_data  = rnext;
                                next_st.rx_valid = 1'b1;
                            end
                        end
                    end else if (st.edges == st.total) begin
                        // Deselect ends the read wherever it stands
                        next_st.sclk  = 1'b0;
                        next_st.cs_n  = 1'b1;
                        next_st.io_oe = 4'h0;
                        next_st.done  = 1'b1;
                        next_st.ph    = H_END;
                    end else if (st.edges < st.tx_end) begin
                        next_st.tx     = st.wide_tx ? {st.tx[35:0], 4'h0} : {st.tx[38:0], 1'b0};
                        next_st.io_out = st.wide_tx ? next_st.tx[39:36] : {3'h0, next_st.tx[39]};
                    end else begin
                        // Release lines for latency and device output
                        next_st.io_oe = 4'h0;
                    end
                end
            end
            H_END: begin
                // Hold deselect for one half period
                next_st.div = st.div + 8'h01;
                if (st.div == HALF_LAST) begin
                    next_st.div = '0;
                    next_st.ph  = H_IDLE;
                end
            end
            default: begin
                next_st.ph = H_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st <= '{ph: H_IDLE, cs_n: 1'b1, meta: 4'hf, sync: 4'hf, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign link.sclk        = st.sclk;
    assign link.cs_n        = st.cs_n;
    assign link.host_io_out = st.io_out;
    assign link.host_io_oe  = st.io_oe;
    assign rx_data          = st.rx_data;
    assign rx_valid         = st.rx_valid;
    assign busy             = (st.ph != H_IDLE);
    assign done             = st.done;

endmodule

//--- hdl/flash_id_pkg.sv
// Notes on behaviour
// - 9Fh returns maker byte, two device bytes
// - Identity read ignored while device busy
// - Bytes past defined ID are undefined
// - Chip select high ends output at once
// - Host keeps identity read clock <=108 MHz
// - Four-bit mode: opcode, data on IO0-IO3
// - AFh accepted only in quad modes
// - AFh data always leaves on four lines
// - 5Ah takes 3 or 4 address bytes
// - Table read waits configured dummy cycles
// - Table data MSB first, after falling edge
// - Address selects starting table byte
// - Table address increments until deselect
// - Host keeps table read clock <=133 MHz
// - Default read latency is eight cycles
// - Address MSB is bit 23 or 31
// - 4Bh returns fixed 64-bit serial number
// - Serial read waits 32 latency clocks
// - Latency clocks ignore IO line levels
// - Serial read ends on deselect; extra undefined
package flash_id_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Opcodes
    localparam logic [7:0] OP_IDENTITY_READ  = 8'h9f;
    localparam logic [7:0] OP_QUAD_IDENTITY  = 8'haf;
    localparam logic [7:0] OP_PARAM_TABLE    = 8'h5a;
    localparam logic [7:0] OP_UNIQUE_SERIAL  = 8'h4b;

    ////////////////////////////////////////////////////////////////////////
    // Phase lengths in serial clocks; reply sizes in bytes
    localparam logic [5:0] OPC_EDGES_SINGLE  = 6'h08;
    localparam logic [5:0] OPC_EDGES_QUAD    = 6'h02;
    localparam logic [5:0] ADDR3_EDGES_SINGLE = 6'h18;
    localparam logic [5:0] ADDR4_EDGES_SINGLE = 6'h20;
    localparam logic [5:0] ADDR3_EDGES_QUAD  = 6'h06;
    localparam logic [5:0] ADDR4_EDGES_QUAD  = 6'h08;
    localparam logic [5:0] UID_LATENCY       = 6'h20;
    localparam logic [3:0] LATENCY_RESET     = 4'h8;
    localparam int         ID_BYTES          = 3;
    localparam int         UID_BYTES         = 8;

    ////////////////////////////////////////////////////////////////////////
    // Clock limits
    localparam int SYS_CLK_HZ        = 25_000_000;
    localparam int ID_MAX_SCLK_HZ    = 108_000_000;
    localparam int TABLE_MAX_SCLK_HZ = 133_000_000;

    ////////////////////////////////////////////////////////////////////////
    // Shared types
    typedef enum logic [2:0] {PH_OPCODE, PH_ADDR, PH_DUMMY, PH_DATA, PH_IGNORE} phase_t;
    typedef enum logic [1:0] {SRC_ID, SRC_TABLE, SRC_UID} source_t;
    typedef enum logic [1:0] {CMD_ID, CMD_QUAD_ID, CMD_TABLE, CMD_UNIQUE} host_cmd_t;

endpackage

//--- hdl/flash_id_responder.sv
module flash_id_responder #(
    parameter logic [7:0]  MAKER_ID     = 8'h11,    // Arbitrary value
    parameter logic [15:0] DEVICE_ID    = 16'h2233, // Arbitrary value
    parameter logic [63:0] SERIAL_ID    = 64'h0123456789abcdef, // Arbitrary
    parameter int          TABLE_BYTES  = 256,
    parameter logic [TABLE_BYTES*8-1:0] TABLE_IMAGE = '0
) (
    spi_link_if.device             link,
    input  wire logic              reset_n,
    input  wire logic              four_bit_command_mode,
    input  wire logic              quad_enable,
    input  wire logic              addr_len_four,
    input  wire logic [3:0]        read_latency,
    input  wire logic              array_busy
);
    import flash_id_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    // The lookup indexes the image with 16 pointer bits
    if (TABLE_BYTES < 1 || TABLE_BYTES > 65536) begin
        $error("TABLE_BYTES out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        phase_t      phase;  // Command phase
        source_t     src;    // Byte source for data phase
        logic [7:0]  opc;    // Opcode shifter
        logic [5:0]  cnt;    // Clocks in current phase
        logic [5:0]  lat;    // Dummy clocks to insert
        logic [31:0] ptr;    // Address, then byte pointer
        logic [2:0]  pos;    // Bit position in current byte
        logic        wide;   // Four lines per clock
        logic        addr4;  // Four-byte address
    } dev_state_t;

    typedef struct packed {
        logic       wide_cmd;
        logic       qe;
        logic       addr4;
        logic [3:0] lat;
        logic       busy;
    } cfg_t;

    dev_state_t st;       // Registered state
    dev_state_t next_st;  // Next state
    cfg_t       cfg_meta; // First synchroniser stage
    cfg_t       cfg;      // Synchronised config
    logic       frame_rst_n; // Low outside a frame
    logic [3:0] io_out;   // Output drive register
    logic [3:0] io_oe;    // Output enable register
    logic [7:0] cur_byte; // Byte under the pointer
    logic [ID_BYTES*8-1:0] id_word; // Maker byte then device bytes
    logic [5:0] addr_edges; // Address clocks needed

    // Deselect acts as an asynchronous reset of the whole command path
    assign frame_rst_n = reset_n & ~link.cs_n;

    // A concatenation cannot be part-selected, so the ID is named first
    assign id_word = {MAKER_ID, DEVICE_ID};

    ////////////////////////////////////////////////////////////////////////
    // Config synchroniser
    // The serial clock only runs inside frames, so a config change is
    // seen two serial clocks after it is made; hosts change config between
    // frames and then send a frame of any kind before relying on it.
    always_ff @(posedge link.sclk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_meta <= '{wide_cmd: 1'b0, qe: 1'b0, addr4: 1'b0, lat: LATENCY_RESET, busy: 1'b0};
            cfg      <= '{wide_cmd: 1'b0, qe: 1'b0, addr4: 1'b0, lat: LATENCY_RESET, busy: 1'b0};
        end else begin
            cfg_meta <= '{wide_cmd: four_bit_command_mode, qe: quad_enable, addr4: addr_len_four,
                          lat: read_latency, busy: array_busy};
            cfg      <= cfg_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte lookup
    // Past the defined space the lines read all ones; hosts must not
    // rely on those bytes.
    always_comb begin
        cur_byte = 8'hff;
        unique case (st.src)
            SRC_ID: begin
                if (st.ptr < 32'(ID_BYTES)) begin
                    cur_byte = id_word[(ID_BYTES - 1 - int'(st.ptr[1:0])) * 8 +: 8];
                end
            end
            SRC_UID: begin
                if (st.ptr < 32'(UID_BYTES)) begin
                    cur_byte = SERIAL_ID[(UID_BYTES - 1 - int'(st.ptr[2:0])) * 8 +: 8];
                end
            end
            SRC_TABLE: begin
                if (st.ptr < 32'(TABLE_BYTES)) begin
                    cur_byte = TABLE_IMAGE[int'(st.ptr[15:0]) * 8 +: 8];
                end
            end
            default: begin
                cur_byte = 8'hff;
            end
        endcase
    end

    // Address length follows the config bit and the bus width
    always_comb begin
        if (st.wide) begin
            addr_edges = st.addr4 ? ADDR4_EDGES_QUAD : ADDR3_EDGES_QUAD;
        end else begin
            addr_edges = st.addr4 ? ADDR4_EDGES_SINGLE : ADDR3_EDGES_SINGLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Rising-edge command sequencer
    always_comb begin
        next_st     = st;
        next_st.cnt = st.cnt + 6'h01;
        unique case (st.phase)
            PH_OPCODE: begin
                // Opcode width follows the four-bit command mode flag
                if (cfg.wide_cmd) begin
                    next_st.opc = {st.opc[3:0], link.io};
                end else begin
                    next_st.opc = {st.opc[6:0], link.io[0]};
                end
                if (next_st.cnt == (cfg.wide_cmd ? OPC_EDGES_QUAD : OPC_EDGES_SINGLE)) begin
                    next_st.cnt   = '0;
                    next_st.ptr   = '0;
                    next_st.pos   = '0;
                    next_st.wide  = cfg.wide_cmd;
                    next_st.addr4 = cfg.addr4;
                    unique case (next_st.opc)
                        OP_IDENTITY_READ: begin
                            // A busy device drops the read and leaves its cycle alone
                            next_st.src   = SRC_ID;
                            next_st.phase = cfg.busy ? PH_IGNORE : PH_DATA;
                        end
                        OP_QUAD_IDENTITY: begin
                            next_st.src   = SRC_ID;
                            next_st.wide  = 1'b1;
                            next_st.phase = (!cfg.busy && (cfg.wide_cmd || cfg.qe)) ? PH_DATA : PH_IGNORE;
                        end
                        OP_PARAM_TABLE: begin
                            next_st.src   = SRC_TABLE;
                            next_st.lat   = {2'b00, cfg.lat};
                            next_st.phase = PH_ADDR;
                        end
                        OP_UNIQUE_SERIAL: begin
                            next_st.src   = SRC_UID;
                            next_st.lat   = UID_LATENCY;
                            next_st.phase = PH_DUMMY;
                        end
                        default: begin
                            // Commands outside this block are left to others
                            next_st.phase = PH_IGNORE;
                        end
                    endcase
                end
            end
            PH_ADDR: begin
                // Address shifts in MSB first; upper bits stay zero for 3 bytes
                if (st.wide) begin
                    next_st.ptr = {st.ptr[27:0], link.io};
                end else begin
                    next_st.ptr = {st.ptr[30:0], link.io[0]};
                end
                if (next_st.cnt == addr_edges) begin
                    next_st.cnt   = '0;
                    next_st.phase = (st.lat == 6'h00) ? PH_DATA : PH_DUMMY;
                end
            end
            PH_DUMMY: begin
                // Lines are not looked at here, so floating levels are harmless
                if (next_st.cnt == st.lat) begin
                    next_st.cnt   = '0;
                    next_st.phase = PH_DATA;
                end
            end
            PH_DATA: begin
                // Stream runs on through following bytes until deselect
                next_st.cnt = '0;
                next_st.pos = st.pos + (st.wide ? 3'h4 : 3'h1);
                if (next_st.pos == 3'h0) begin
                    next_st.ptr = st.ptr + 32'h1;
                end
            end
            PH_IGNORE: begin
                next_st.cnt = '0;
            end
            default: begin
                next_st.phase = PH_IGNORE;
            end
        endcase
    end

    // Sequencer register
    always_ff @(posedge link.sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            st <= '{phase: PH_OPCODE, src: SRC_ID, default: '0};
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Falling-edge output driver
    // Data changes on the falling edge so the host samples a settled bit
    // on the next rising edge.
    always_ff @(negedge link.sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            io_out <= 4'h0;
            io_oe  <= 4'h0;
        end else if (st.phase == PH_DATA) begin
            if (st.wide) begin
                io_out <= st.pos[2] ? cur_byte[3:0] : cur_byte[7:4];
                io_oe  <= 4'hf;
            end else begin
                io_out <= {2'b00, cur_byte[3'h7 - st.pos], 1'b0};
                io_oe  <= 4'h2;
            end
        end else begin
            io_out <= 4'h0;
            io_oe  <= 4'h0;
        end
    end

    assign link.dev_io_out = io_out;
    assign link.dev_io_oe  = io_oe;

endmodule

//--- hdl/spi_link_if.sv
interface spi_link_if;
    logic       sclk;        // Serial clock from host
    logic       cs_n;        // Chip select, active low
    logic [3:0] host_io_out; // Host drive values
    logic [3:0] host_io_oe;  // Host drive enables
    logic [3:0] dev_io_out;  // Device drive values
    logic [3:0] dev_io_oe;   // Device drive enables
    logic [3:0] io;          // Resolved line levels

    // Undriven lines float to the pull-up level
    assign io = (dev_io_out & dev_io_oe) | (host_io_out & host_io_oe) | ~(dev_io_oe | host_io_oe);

    modport host (output sclk, output cs_n, output host_io_out, output host_io_oe, input io);
    modport device (input sclk, input cs_n, input io, output dev_io_out, output dev_io_oe);
endinterface

//--- testbench/flash_id_sva.sv
module flash_id_sva (
    input wire logic       clk_sys,
    input wire logic       reset_n,
    input wire logic       sclk,
    input wire logic       cs_n,
    input wire logic [3:0] host_io_out,
    input wire logic [3:0] host_io_oe,
    input wire logic [3:0] dev_io_out,
    input wire logic [3:0] dev_io_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // Serial clock rises seen in the current frame
    logic [5:0] rises;

    // Deselect clears the count at once, like the device's command state
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            rises <= 6'h00;
        end else if (rises != 6'h3f) begin
            rises <= rises + 6'h01;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    a_deselect_release: assert property (cs_n |-> dev_io_oe == 4'h0)
        else $error("device drives while deselected");
    a_oe_lane_shape: assert property (dev_io_oe inside {4'h0, 4'h2, 4'hf})
        else $error("device drive lanes malformed");
    a_no_contention: assert property ((dev_io_oe & host_io_oe) == 4'h0)
        else $error("both ends drive one line");
    // Single-lane data only follows a full eight-clock opcode
    a_data_after_cmd: assert property (dev_io_oe != 4'h0 |->
        rises >= ((dev_io_oe == 4'h2) ? 6'h08 : 6'h02))
        else $error("device drives before opcode complete");
    a_dev_holds_high: assert property (sclk && $past(sclk) && !cs_n |-> $stable(dev_io_out))
        else $error("device data moved while clock high");
    a_host_holds_high: assert property (sclk && $past(sclk) |-> $stable(host_io_out))
        else $error("host data moved while clock high");
    a_idle_clock_low: assert property (cs_n |-> !sclk)
        else $error("serial clock high outside frame");
    a_frame_quiet: assert property ($fell(cs_n) |-> (dev_io_oe == 4'h0) [*2])
        else $error("device drives at frame start");
endmodule

//--- testbench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import flash_id_pkg::*;
    localparam logic [7:0]   MAKER  = 8'h5c;               // Arbitrary value
    localparam logic [15:0]  DEVID  = 16'h6e71;            // Arbitrary value
    localparam logic [63:0]  SERIAL = 64'h8877665544332211; // Arbitrary value
    localparam logic [127:0] TBL    = 128'hf0e1d2c3b4a5968778695a4b3c2d1e0f;
    logic clk_sys = 1'b0, reset_n = 1'b0, start = 1'b0, array_busy = 1'b0;
    logic four_bit_command_mode = 1'b0, quad_enable = 1'b0, addr_len_four = 1'b0;
    logic [3:0] read_latency = 4'h8;
    host_cmd_t cmd = CMD_ID;
    logic [31:0] address = 32'h0;
    logic [7:0] byte_count = 8'h0, rx_data;
    logic rx_valid, busy, done;
    int error_cnt = 0, samples_checked = 0, cycles = 0;
    logic [7:0] got[$], exp[$];
    spi_link_if link ();
    flash_id_responder #(.MAKER_ID(MAKER), .DEVICE_ID(DEVID), .SERIAL_ID(SERIAL), .TABLE_BYTES(16),
        .TABLE_IMAGE(TBL)) i_flash_id_responder (.link(link), .reset_n, .four_bit_command_mode,
        .quad_enable, .addr_len_four, .read_latency, .array_busy);
    flash_id_host i_flash_id_host (.link(link), .clk_sys, .reset_n, .start, .cmd, .address, .byte_count,
        .four_bit_command_mode, .addr_len_four, .read_latency, .rx_data, .rx_valid, .busy, .done);
    flash_id_sva i_flash_id_sva (.clk_sys, .reset_n, .sclk(link.sclk), .cs_n(link.cs_n),
        .host_io_out(link.host_io_out), .host_io_oe(link.host_io_oe), .dev_io_out(link.dev_io_out),
        .dev_io_oe(link.dev_io_oe));
    ////////////////////////////////////////////////////////////////////////
    always #20 clk_sys = ~clk_sys;
    // Hang guard, well above the longest expected run
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            error_cnt++;
            finish_test();
        end
    end
    task finish_test();
        $display("checked %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Single point of comparison; a missing byte arrives as unknown and fails
    task check(input string name, input logic [7:0] seen, input logic [7:0] expected);
        samples_checked++;
        if (seen !== expected) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", name, expected, seen);
        end
    endtask
    // One frame; bytes are taken at the falling edge where the pulse is settled
    task xfer(input host_cmd_t c, input logic [31:0] a, input int n);
        got.delete();
        @(negedge clk_sys);
        cmd = c;
        address = a;
        byte_count = 8'(n);
        start = 1'b1;
        @(negedge clk_sys);
        start = 1'b0;
        for (int k = 0; k < 8000; k++) begin
            @(negedge clk_sys);
            if (rx_valid === 1'b1) got.push_back(rx_data);
            if (done === 1'b1) break;
        end
        while (busy !== 1'b0) @(negedge clk_sys);
    endtask
    // Config reaches the device only through sclk edges, so two spare frames follow
    task cfg(input logic q, qe, a4, input logic [3:0] lat, input logic bsy);
        @(negedge clk_sys);
        {four_bit_command_mode, quad_enable, addr_len_four, read_latency, array_busy} = {q, qe, a4, lat, bsy};
        repeat (2) xfer(CMD_ID, 32'h0, 0);
    endtask
    task cmp(input string name);
        check({name, "_count"}, 8'(got.size()), 8'(exp.size()));
        foreach (exp[i]) begin
            check($sformatf("%s[%0d]", name, i), (i < got.size()) ? got[i] : 8'hxx, exp[i]);
        end
        exp.delete();
        $display("test %s done", name);
    endtask
    task id_exp();
        exp = '{MAKER, DEVID[15:8], DEVID[7:0]};
    endtask
    task uid_exp();
        for (int i = 7; i >= 0; i--) exp.push_back(SERIAL[8*i+:8]);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(negedge clk_sys);
        reset_n = 1'b1;
        // Identity read, one byte past the end reads as filler
        id_exp();
        exp.push_back(8'hff);
        xfer(CMD_ID, 32'h0, 4);
        cmp("identity");
        cfg(0, 0, 0, 4'h8, 1);
        exp = '{8'hff, 8'hff};
        xfer(CMD_ID, 32'h0, 2);
        cmp("busy_id");
        // Table read, 3-byte address, eight dummies, runs on
        cfg(0, 0, 0, 4'h8, 0);
        for (int i = 5; i < 8; i++) exp.push_back(TBL[8*i+:8]);
        xfer(CMD_TABLE, 32'h5, 3);
        cmp("table3");
        // 4-byte address, no latency, across the table end
        cfg(0, 0, 1, 4'h0, 0);
        exp = '{TBL[119:112], TBL[127:120], 8'hff};
        xfer(CMD_TABLE, 32'he, 3);
        cmp("table4");
        uid_exp();
        exp.push_back(8'hff);
        xfer(CMD_UNIQUE, 32'h0, 9);
        cmp("serial");
        exp = '{8'hff, 8'hff};
        xfer(CMD_QUAD_ID, 32'h0, 2);
        cmp("quad_refused");
        cfg(0, 1, 0, 4'h8, 0);
        id_exp();
        xfer(CMD_QUAD_ID, 32'h0, 3);
        cmp("quad_id");
        // Four-bit command mode throughout
        cfg(1, 0, 0, 4'h8, 0);
        id_exp();
        xfer(CMD_ID, 32'h0, 3);
        cmp("wide_cmd_id");
        uid_exp();
        xfer(CMD_UNIQUE, 32'h0, 8);
        cmp("wide_cmd_serial");
        id_exp();
        xfer(CMD_QUAD_ID, 32'h0, 3);
        cmp("wide_cmd_quad_id");
        // Table read with address nibbles and eight dummies
        exp = '{TBL[31:24], TBL[39:32]};
        xfer(CMD_TABLE, 32'h3, 2);
        cmp("wide_cmd_table");
        finish_test();
    end
endmodule
